/* File: rtl/capreg_pkg.sv */
package capreg_pkg;

  // Register byte offsets
  localparam logic [11:0] CAP_HDR_OFS      = 12'h040;
  localparam logic [11:0] DEV_CAP_OFS      = 12'h044;
  localparam logic [11:0] LOCK_CTL_OFS     = 12'h050;
  localparam logic [11:0] PAYLOAD_STAT_OFS = 12'h054;

  // Header dword field positions
  localparam int CAP_ID_LSB   = 0;
  localparam int NXT_PTR_LSB  = 8;
  localparam int VERSION_LSB  = 16;
  localparam int PORT_TYPE_LSB = 20;
  localparam int SLOT_BIT     = 24;
  localparam int MSG_VEC_LSB  = 25;

  // Device capabilities field positions
  localparam int MPS_LSB      = 0;
  localparam int BORROW_LSB   = 3;
  localparam int WTAG_BIT     = 5;
  localparam int FAST_LAT_LSB = 6;
  localparam int DEEP_LAT_LSB = 9;
  localparam int ATTN_BIT     = 12;

  // Lock control field position
  localparam int UNLOCK_BIT   = 0;

  // Constant and reset values
  localparam logic [7:0] CAP_ID_VAL      = 8'h10;
  localparam logic [3:0] VERSION_RST     = 4'h2;
  localparam logic [3:0] TYPE_UPSTREAM   = 4'h5;
  localparam logic [3:0] TYPE_DOWNSTREAM = 4'h6;
  localparam logic       SLOT_RST        = 1'h0;
  localparam logic [4:0] MSG_VEC_VAL     = 5'h00;
  localparam logic [2:0] MPS_RST         = 3'h4;
  localparam logic [1:0] BORROW_VAL      = 2'h0;
  localparam logic       WTAG_RST        = 1'h1;
  localparam logic [2:0] FAST_LAT_VAL    = 3'h0;
  localparam logic [2:0] DEEP_LAT_VAL    = 3'h0;
  localparam logic       ATTN_VAL        = 1'h0;
  localparam logic       UNLOCK_RST      = 1'h0;

  // Payload size decode
  localparam int          PAYLOAD_W     = 13;
  localparam logic [12:0] PAYLOAD_128   = 13'h0080;

  // Strap capture: sample after this many edges past reset release
  localparam logic [1:0]  STRAP_SETTLE  = 2'h2;

endpackage : capreg_pkg

/* File: rtl/capreg_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface capreg_if;
  import capreg_pkg::*;
  logic [2:0]           code;
  logic [PAYLOAD_W-1:0] bytes;
  modport src (output code, input bytes);
  modport dec (input code, output bytes);
endinterface : capreg_if

`default_nettype wire

/* File: rtl/payload_decode.sv */
`timescale 1ns/1ps
`default_nettype none

module payload_decode
  import capreg_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  capreg_if.dec     dp
);

  typedef struct packed {
    logic [PAYLOAD_W-1:0] bytes;
  } dec_state_t;

  dec_state_t q;
  dec_state_t d;

  function automatic logic [PAYLOAD_W-1:0] code_to_bytes(input logic [2:0] c);
    if (c > 3'h5) begin
      return PAYLOAD_128;
    end
    return PAYLOAD_W'(PAYLOAD_128 << c);
  endfunction : code_to_bytes

  always_comb begin
    d       = q;
    d.bytes = code_to_bytes(dp.code);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.bytes <= PAYLOAD_128;
    end else begin
      q <= d;
    end
  end

  assign dp.bytes = q.bytes;

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence reserved_code_s;
    dp.code == 3'h6 || dp.code == 3'h7;
  endsequence

  reserved_code_a: assert property (reserved_code_s |=> dp.bytes == 13'h0080)
    else $error("reserved payload code not treated as 128 bytes");

  legal_code_a: assert property (dp.code == 3'h5 |=> dp.bytes == 13'h1000)
    else $error("payload code 5 not decoded as 4096 bytes");

endmodule : payload_decode

`default_nettype wire

/* File: rtl/pcie_capability_header_regs.sv */
// What this block does
// - Header bits 7:0 read 0x10.
// - Header bits 15:8 hold next pointer, lockable.
// - Header bits 19:16 version, lockable, resets 0x2.
// - Port type reads 0x5 upstream, 0x6 downstream.
// - Slot bit lockable, zero by default, zero upstream.
// - Message number bits 29:25 read zero.
// - Codes 0x6 and 0x7 act as 128 bytes.
// - Wide tag bit 5 lockable, default one.
// - Fast idle latency bits 8:6 read zero.
// - Deep idle latency bits 11:9 read zero.
// - Attention button bit 12 reads zero.
`timescale 1ns/1ps
`default_nettype none

module pcie_capability_header_regs
  import capreg_pkg::*;
#(
  parameter int          ADDR_W           = 12,
  parameter logic [7:0]  NEXT_PTR_DEFAULT = 8'h00
)(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  input  wire logic [2:0]           pprot,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 upstream_strap,
  output logic                      port_is_upstream,
  output logic                      slot_present,
  output logic                      wide_tag_en,
  output logic [PAYLOAD_W-1:0]      payload_bytes
);

  if (ADDR_W < 7 || ADDR_W > 12) begin : g_addr_check
    $error("ADDR_W must lie between 7 and 12");
  end

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic        sync1;
    logic        sync2;
    logic [1:0]  strap_cnt;
    logic        port_up;
    logic [7:0]  next_ptr;
    logic [3:0]  version;
    logic        slot;
    logic [2:0]  mps;
    logic        wtag;
    logic        unlock;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } regs_state_t;

  regs_state_t q;
  regs_state_t d;

  capreg_if pl ();

  //////////////////////////////////////////////////////////////////////////////
  // Decoding

  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    return a[ADDR_W-1:2] == ofs[ADDR_W-1:2];
  endfunction : is_reg

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return is_reg(a, CAP_HDR_OFS) || is_reg(a, DEV_CAP_OFS) ||
           is_reg(a, LOCK_CTL_OFS) || is_reg(a, PAYLOAD_STAT_OFS);
  endfunction : is_mapped

  logic [31:0] hdr_word;
  logic [31:0] dcap_word;
  logic [31:0] rd_word;
  logic        setup_ph;
  logic        wr_take;
  logic [3:0]  port_type;

  always_comb begin
    port_type = q.port_up ? TYPE_UPSTREAM : TYPE_DOWNSTREAM;
    hdr_word = 32'h0000_0000;
    hdr_word[CAP_ID_LSB +: 8]    = CAP_ID_VAL;
    hdr_word[NXT_PTR_LSB +: 8]   = q.next_ptr;
    hdr_word[VERSION_LSB +: 4]   = q.version;
    hdr_word[PORT_TYPE_LSB +: 4] = port_type;
    hdr_word[SLOT_BIT]           = q.slot;
    hdr_word[MSG_VEC_LSB +: 5]   = MSG_VEC_VAL;
    dcap_word = 32'h0000_0000;
    dcap_word[MPS_LSB +: 3]      = q.mps;
    dcap_word[BORROW_LSB +: 2]   = BORROW_VAL;
    dcap_word[WTAG_BIT]          = q.wtag;
    dcap_word[FAST_LAT_LSB +: 3] = FAST_LAT_VAL;
    dcap_word[DEEP_LAT_LSB +: 3] = DEEP_LAT_VAL;
    dcap_word[ATTN_BIT]          = ATTN_VAL;
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (is_reg(paddr, CAP_HDR_OFS)) begin
      rd_word = hdr_word;
    end else if (is_reg(paddr, DEV_CAP_OFS)) begin
      rd_word = dcap_word;
    end else if (is_reg(paddr, LOCK_CTL_OFS)) begin
      rd_word[UNLOCK_BIT] = q.unlock;
    end else if (is_reg(paddr, PAYLOAD_STAT_OFS)) begin
      rd_word[PAYLOAD_W-1:0] = pl.bytes;
    end
  end

  assign setup_ph = psel && !penable;
  assign wr_take  = psel && penable && q.pready && pwrite;
  assign pl.code  = q.mps;

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    // Strap passes two flops, then is caught once after reset release
    d.sync1 = upstream_strap;
    d.sync2 = q.sync1;
    if (q.strap_cnt != 2'h3) begin
      d.strap_cnt = q.strap_cnt + 2'h1;
    end
    if (q.strap_cnt == STRAP_SETTLE) begin
      d.port_up = q.sync2;
    end

    // Answer in the first access cycle, no wait states
    d.pready  = setup_ph;
    d.pslverr = setup_ph && !is_mapped(paddr);
    if (setup_ph) begin
      d.prdata = pwrite ? 32'h0000_0000 : rd_word;
    end

    // Lockable fields accept writes only while unlocked
    if (wr_take && q.unlock) begin
      if (is_reg(paddr, CAP_HDR_OFS)) begin
        if (pstrb[1]) begin
          d.next_ptr = pwdata[NXT_PTR_LSB +: 8];
        end
        if (pstrb[2]) begin
          d.version = pwdata[VERSION_LSB +: 4];
        end
        if (pstrb[3]) begin
          d.slot = pwdata[SLOT_BIT];
        end
      end
      if (is_reg(paddr, DEV_CAP_OFS) && pstrb[0]) begin
        d.mps  = pwdata[MPS_LSB +: 3];
        d.wtag = pwdata[WTAG_BIT];
      end
    end

    // Only a privileged write may open or close the lock
    if (wr_take && pprot[0] && pstrb[0] && is_reg(paddr, LOCK_CTL_OFS)) begin
      d.unlock = pwdata[UNLOCK_BIT];
    end

    // Slot has no meaning on the upstream port
    if (q.port_up) begin
      d.slot = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.sync1     <= 1'b0;
      q.sync2     <= 1'b0;
      q.strap_cnt <= 2'h0;
      q.port_up   <= 1'b0;
      q.next_ptr  <= NEXT_PTR_DEFAULT;
      q.version   <= VERSION_RST;
      q.slot      <= SLOT_RST;
      q.mps       <= MPS_RST;
      q.wtag      <= WTAG_RST;
      q.unlock    <= UNLOCK_RST;
      q.pready    <= 1'b0;
      q.pslverr   <= 1'b0;
      q.prdata    <= 32'h0000_0000;
    end else begin
      q <= d;
    end
  end

  payload_decode u_decode (
    .pclk    (pclk),
    .presetn (presetn),
    .dp      (pl.dec)
  );

  assign prdata           = q.prdata;
  assign pready           = q.pready;
  assign pslverr          = q.pslverr;
  assign port_is_upstream = q.port_up;
  assign slot_present     = q.slot;
  assign wide_tag_en      = q.wtag;
  assign payload_bytes    = pl.bytes;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence setup_s;
    psel && !penable;
  endsequence

  sequence hdr_read_s;
    setup_s ##0 (!pwrite && is_reg(paddr, CAP_HDR_OFS));
  endsequence

  sequence dcap_read_s;
    setup_s ##0 (!pwrite && is_reg(paddr, DEV_CAP_OFS));
  endsequence

  sequence locked_hdr_write_s;
    psel && penable && pready && pwrite && !q.unlock && is_reg(paddr, CAP_HDR_OFS);
  endsequence

  apb_answer_a: assert property (setup_s |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");

  capability_identifier_value_a: assert property (hdr_read_s |=> prdata[7:0] == 8'h10)
    else $error("capability identifier not 0x10");

  port_type_a: assert property (hdr_read_s |=>
    prdata[23:20] == (port_is_upstream ? 4'h5 : 4'h6))
    else $error("port type does not follow strap");

  msg_vector_a: assert property (hdr_read_s |=> prdata[31:25] == 7'h00)
    else $error("message number or reserved bits not zero");

  dcap_zeros_a: assert property (dcap_read_s |=>
    prdata[4:3] == 2'h0 && prdata[12:6] == 7'h00)
    else $error("hardwired device capability bits not zero");

  locked_write_a: assert property (locked_hdr_write_s |=>
    $stable(q.next_ptr) && $stable(q.version) && $stable(q.slot))
    else $error("lockable field changed while locked");

  next_ptr_wr_a: assert property (
    wr_take && q.unlock && is_reg(paddr, CAP_HDR_OFS) && pstrb[1]
    |=> q.next_ptr == $past(pwdata[15:8]))
    else $error("next pointer not loaded by unlocked write");

  slot_upstream_a: assert property (port_is_upstream |=> !slot_present)
    else $error("slot flag set on upstream port");

  unmapped_err_a: assert property (setup_s ##0 !is_mapped(paddr) |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");

  payload_track_a: assert property (
    q.mps[2:1] == 2'h3 ##1 q.mps[2:1] == 2'h3 |-> payload_bytes == 13'h0080)
    else $error("reserved payload code not shown as 128 bytes");

  sequence open_dcap_write_s;
    wr_take && q.unlock && is_reg(paddr, DEV_CAP_OFS) && pstrb[0];
  endsequence

  sequence locked_dcap_write_s;
    wr_take && !q.unlock && is_reg(paddr, DEV_CAP_OFS);
  endsequence

  version_wr_a: assert property (
    wr_take && q.unlock && is_reg(paddr, CAP_HDR_OFS) && pstrb[2]
    |=> q.version == $past(pwdata[19:16]))
    else $error("version not loaded by unlocked write");

  dcap_wr_a: assert property (open_dcap_write_s |=>
    q.mps == $past(pwdata[2:0]) && q.wtag == $past(pwdata[5]))
    else $error("payload code or wide tag not loaded by unlocked write");

  dcap_locked_a: assert property (locked_dcap_write_s |=>
    $stable(q.mps) && $stable(q.wtag))
    else $error("device capability field changed while locked");

  lock_priv_a: assert property (
    wr_take && !pprot[0] && is_reg(paddr, LOCK_CTL_OFS) |=> $stable(q.unlock))
    else $error("lock control changed by unprivileged write");

  read_hold_a: assert property (!setup_ph |=> $stable(prdata))
    else $error("read data changed without a setup cycle");

  strap_hold_a: assert property (q.strap_cnt == 2'h3 |=> $stable(port_is_upstream))
    else $error("port type changed after strap capture");

endmodule : pcie_capability_header_regs

`default_nettype wire

/* File: bench/pcie_capability_header_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module pcie_capability_header_regs_tb_top
  import capreg_pkg::*;
;
  logic                 pclk;
  logic                 presetn;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [11:0]          paddr;
  logic [31:0]          pwdata;
  logic [3:0]           pstrb;
  logic [2:0]           pprot;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 upstream_strap;
  logic                 port_is_upstream;
  logic                 slot_present;
  logic                 wide_tag_en;
  logic [PAYLOAD_W-1:0] payload_bytes;
  integer               miscompares;
  integer               comparisons;
  integer               seed;
  logic [31:0]          rnd;
  logic [33:0]          cur;
  logic                 up;
  // Each note: {data checked, expected error, expected data}
  logic [33:0]          notes[$];

  pcie_capability_header_regs i_dut (
    .pclk             (pclk),
    .presetn          (presetn),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .pstrb            (pstrb),
    .pprot            (pprot),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .upstream_strap   (upstream_strap),
    .port_is_upstream (port_is_upstream),
    .slot_present     (slot_present),
    .wide_tag_en      (wide_tag_en),
    .payload_bytes    (payload_bytes)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  function automatic logic [31:0] hdr(input logic [7:0] p, input logic [3:0] v,
                                      input logic s, input logic u);
    return {2'h0, 5'h00, s, (u ? 4'h5 : 4'h6), v, p, 8'h10};
  endfunction : hdr

  ////////////////////////////////////////////////////////////////////////////
  // APB master: setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [2:0] pr, input logic [33:0] note);
    int n;
    notes.push_back(note);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    pprot   <= pr;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n = n + 1;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      check(32'h0, 32'h1);
      finish_test;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [2:0] pr);
    apb(1'b1, a, d, s, pr, {2'b00, 32'h0});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    rnd = $random(seed);
    apb(1'b0, a, rnd, 4'hf, 3'h0, {2'b10, exp});
  endtask : rd

  // Watches completed transfers and compares them against the oldest note
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (notes.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        cur = notes.pop_front();
        check({31'h0, pslverr}, {31'h0, cur[32]});
        if (cur[33]) begin
          check(prdata, cur[31:0]);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic run_pass(input logic u);
    logic [31:0] d;
    presetn        <= 1'b0;
    upstream_strap <= u;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    check({31'h0, port_is_upstream}, {31'h0, u});
    check({31'h0, wide_tag_en}, 32'h1);
    check({19'h0, payload_bytes}, 32'h0000_0800);
    rd(CAP_HDR_OFS, hdr(8'h00, 4'h2, 1'b0, u));
    rd(DEV_CAP_OFS, 32'h0000_0024);
    rd(PAYLOAD_STAT_OFS, 32'h0000_0800);
    rnd = $random(seed);
    wr(CAP_HDR_OFS, rnd, 4'hf, 3'h1);
    rnd = $random(seed);
    wr(DEV_CAP_OFS, rnd, 4'hf, 3'h1);
    wr(LOCK_CTL_OFS, 32'h0000_0001, 4'hf, 3'h0);
    rd(CAP_HDR_OFS, hdr(8'h00, 4'h2, 1'b0, u));
    rd(DEV_CAP_OFS, 32'h0000_0024);
    rd(LOCK_CTL_OFS, 32'h0000_0000);
    wr(LOCK_CTL_OFS, 32'h0000_0001, 4'hf, 3'h1);
    rd(LOCK_CTL_OFS, 32'h0000_0001);
    wr(CAP_HDR_OFS, 32'hffff_5cff, 4'h2, 3'h0);
    rd(CAP_HDR_OFS, hdr(8'h5c, 4'h2, 1'b0, u));
    wr(CAP_HDR_OFS, 32'hfff3_a0ff, 4'hf, 3'h0);
    rd(CAP_HDR_OFS, hdr(8'ha0, 4'h3, ~u, u));
    check({31'h0, slot_present}, {31'h0, ~u});
    for (int c = 0; c < 8; c++) begin
      d = $random(seed);
      d[2:0] = c[2:0];
      d[5] = c[0];
      wr(DEV_CAP_OFS, d, 4'hf, 3'h0);
      rd(DEV_CAP_OFS, {26'h0, c[0], 2'b00, c[2:0]});
      rd(PAYLOAD_STAT_OFS, (c > 5) ? 32'h80 : (32'h80 << c));
      check({19'h0, payload_bytes}, (c > 5) ? 32'h80 : (32'h80 << c));
      check({31'h0, wide_tag_en}, {31'h0, c[0]});
    end
    wr(LOCK_CTL_OFS, 32'h0000_0000, 4'hf, 3'h1);
    wr(CAP_HDR_OFS, 32'h0004_33ff, 4'hf, 3'h0);
    rd(CAP_HDR_OFS, hdr(8'ha0, 4'h3, ~u, u));
    apb(1'b0, 12'h060, 32'h0, 4'hf, 3'h0, {2'b11, 32'h0});
    apb(1'b1, 12'h064, 32'hffff_ffff, 4'hf, 3'h1, {2'b01, 32'h0});
  endtask : run_pass

  initial begin
    seed           = 38;
    miscompares    = 0;
    comparisons    = 0;
    presetn        = 1'b0;
    psel           = 1'b0;
    penable        = 1'b0;
    pwrite         = 1'b0;
    paddr          = 12'h000;
    pwdata         = 32'h0;
    pstrb          = 4'h0;
    pprot          = 3'h0;
    upstream_strap = 1'b0;
    rnd            = $random(seed);
    up             = rnd[0];
    for (int p = 0; p < 2; p++) begin
      run_pass(up);
      up = ~up;
    end
    finish_test;
  end

endmodule : pcie_capability_header_regs_tb_top

`default_nettype wire
